// ===== hdl/edint_dev.sv
`timescale 1ns/1ps
`include "edint_map.svh"
// Contract
// [RULE1] Software release mode holds request until cleared
// [RULE2] Hardware mode drops request, drives vector on acknowledge
// [RULE3] Release mode chosen by mode select bit
// [RULE4] Line enable bit gates every request
// [RULE5] One programmable common vector for all sources
// [RULE6] Data stored flag tracks unread FIFO entries
// [RULE7] Stored request releases on write, reasserts if nonempty
// [RULE8] Full flag sticky until FIFO clear or reset
// [RULE9] Full request releases on write, reasserts if full
// [RULE10] Half flag follows fill at least half
// [RULE11] Half request releases on write, reasserts if half
// [RULE12] Rollover flag set on time stamp wrap
// [RULE13] Rollover write one clears flag and request
// [RULE14] Change mode uses channel enable mask
// [RULE15] Polarity bit sets active level per channel
// [RULE16] Definition bit picks any change or activation
// [RULE17] Channel pending latched until write one clears
// [RULE18] Request held while any pending bit set
// [RULE19] Pattern mode compares, disabled channels don't care
// [RULE20] Pattern match sets pending bit zero only
// [RULE21] Definition zero any change, one activation
// [RULE22] Enable one enables, zero disables or ignores
// [RULE23] Evaluate polarity adjusted samples once per tick
// [RULE24] Reset clears enables, pendings, flags, request
module edint_dev (
	// Clock and reset.
	input  wire logic                 i_clock,
	input  wire logic                 i_rst_n,
	// Link to the host.
	edint_if.dev                      bus,
	// FIFO and time base status.
	input  wire logic                 i_fifo_empty,
	input  wire logic                 i_fifo_full,
	input  wire logic                 i_fifo_half,
	input  wire logic                 i_ts_wrap,
	output logic                      o_fifo_clear,
	// Debounced channel samples.
	input  wire logic                 i_sample_tick,
	input  wire edint_pkg::edint_word_t i_inputs
);
	import edint_pkg::*;

	edint_word_t mic;
	edint_word_t polarity;
	edint_word_t chan_enable;
	edint_word_t definition;
	edint_word_t pending;
	edint_word_t prev_active;
	logic        prev_valid;
	logic        full_flag;
	logic        rollover_flag;
	logic        stored_req;
	logic        full_req;
	logic        half_req;
	logic        ack_hold;
	edint_word_t rdata;
	edint_word_t active;
	edint_word_t chan_event;
	edint_word_t next_pending;
	logic        pattern_hit;
	logic        wr_csr;
	logic        wr_pend;
	logic        any_set;
	logic        any_cause;
	logic        hw_release;

	// Write decodes for the two clear-by-one registers.
	assign wr_csr  = bus.wr && (bus.addr == `EDINT_OFF_CSR);
	assign wr_pend = bus.wr && (bus.addr == `EDINT_OFF_PEND);
	assign hw_release = mic[`EDINT_MIC_IT]; // see [RULE3]

	// Configuration registers; reset leaves every enable off.
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			mic         <= `EDINT_RST_REG; // see [RULE24]
			polarity    <= `EDINT_RST_REG;
			chan_enable <= `EDINT_RST_REG;
			definition  <= `EDINT_RST_REG;
		end else if (bus.wr) begin
			unique case (bus.addr)
				`EDINT_OFF_MIC:  mic         <= bus.wdata;
				`EDINT_OFF_POL:  polarity    <= bus.wdata;
				`EDINT_OFF_CHEN: chan_enable <= bus.wdata;
				`EDINT_OFF_DEF:  definition  <= bus.wdata;
				default: ;
			endcase
		end
	end

	// FIFO clear command is a one-cycle pulse on a write of one.
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_fifo_clear <= 1'b0;
		end else begin
			o_fifo_clear <= wr_csr && bus.wdata[`EDINT_CSR_RFF];
		end
	end

	// Sticky full flag: only a FIFO clear or reset removes it.
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			full_flag <= 1'b0;
		end else if (i_fifo_full) begin
			full_flag <= 1'b1; // see [RULE8]
		end else if (wr_csr && bus.wdata[`EDINT_CSR_RFF]) begin
			full_flag <= 1'b0;
		end
	end

	// Rollover flag; a wrap in the clearing cycle still wins.
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			rollover_flag <= 1'b0;
		end else if (i_ts_wrap) begin
			rollover_flag <= 1'b1; // see [RULE12]
		end else if (wr_csr && bus.wdata[`EDINT_CSR_TSR]) begin
			rollover_flag <= 1'b0; // see [RULE13]
		end
	end

	// Status request latches: a write of one releases for a cycle, but a
	// standing condition sets the latch again, so the request comes back.
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			stored_req <= 1'b0;
			full_req   <= 1'b0;
			half_req   <= 1'b0;
		end else begin
			stored_req <= !i_fifo_empty && !(wr_csr && bus.wdata[`EDINT_CSR_DS]
				&& stored_req); // see [RULE6] [RULE7]
			full_req   <= full_flag && !(wr_csr && bus.wdata[`EDINT_CSR_FF]
				&& full_req); // see [RULE9]
			half_req   <= i_fifo_half && !(wr_csr && bus.wdata[`EDINT_CSR_HF]
				&& half_req); // see [RULE10] [RULE11]
		end
	end

	// Polarity-adjusted samples; the first tick after reset only primes.
	assign active = i_inputs ^ polarity; // see [RULE15]

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			prev_active <= `EDINT_RST_REG;
			prev_valid  <= 1'b0;
		end else if (i_sample_tick) begin
			prev_active <= active; // see [RULE23]
			prev_valid  <= 1'b1;
		end
	end

	// Channel event and pattern evaluation, once per sample tick.
	always_comb begin
		chan_event  = '0;
		pattern_hit = &((active ~^ definition) | ~chan_enable); // see [RULE19] [RULE22]
		if (i_sample_tick && prev_valid) begin
			if (mic[`EDINT_MIC_PAT]) begin
				chan_event[0] = pattern_hit; // see [RULE20]
			end else begin
				// Definition one means activation only, zero means any change.
				chan_event = chan_enable & ((definition & active & ~prev_active)
					| (~definition & (active ^ prev_active))); // see [RULE14] [RULE16] [RULE21]
			end
		end
		next_pending = (pending & ~(wr_pend ? bus.wdata : 16'h0000)) | chan_event;
	end

	// Pending latches; a new event beats a simultaneous clear.
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			pending <= `EDINT_RST_REG;
		end else begin
			pending <= next_pending; // see [RULE17]
		end
	end

	// Any enabled cause keeps the request alive.
	assign any_cause = (|pending) // see [RULE18]
		|| (stored_req && mic[`EDINT_MIC_STORED_IRQ_ENABLE])
		|| (full_req && mic[`EDINT_MIC_FULL_IRQ_ENABLE])
		|| (half_req && mic[`EDINT_MIC_HALF_IRQ_ENABLE])
		|| (rollover_flag && mic[`EDINT_MIC_ROLLOVER_IRQ_ENABLE]);
	assign any_set = (|chan_event) || i_ts_wrap || wr_csr || wr_pend;

	// After a hardware acknowledge the request stays down until something
	// new happens; otherwise a held condition would re-request forever.
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			ack_hold <= 1'b0;
		end else if (any_set || !hw_release) begin
			ack_hold <= 1'b0;
		end else if (bus.iack) begin
			ack_hold <= 1'b1; // see [RULE2]
		end
	end

	// Request: line enable gates all; software mode ignores acknowledge.
	assign bus.irq = mic[`EDINT_MIC_IE] && any_cause // see [RULE4] [RULE1]
		&& !(hw_release && (bus.iack || ack_hold)); // see [RULE2]
	// Vector is driven only in the acknowledge cycle of hardware mode.
	assign bus.vec_oe = hw_release && bus.iack && mic[`EDINT_MIC_IE] && any_cause;
	assign bus.vec = mic[`EDINT_MIC_VEC_MSB:`EDINT_MIC_VEC_LSB]; // see [RULE5]

	// Read data appear the cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			rdata <= `EDINT_RST_REG;
		end else if (bus.rd) begin
			unique case (bus.addr)
				`EDINT_OFF_MIC:  rdata <= mic;
				`EDINT_OFF_POL:  rdata <= polarity;
				`EDINT_OFF_CHEN: rdata <= chan_enable;
				`EDINT_OFF_DEF:  rdata <= definition;
				`EDINT_OFF_PEND: rdata <= pending;
				`EDINT_OFF_CSR:  rdata <= {12'h000, rollover_flag, i_fifo_half,
					full_flag, !i_fifo_empty};
				default:         rdata <= 16'h0000;
			endcase
		end else begin
			rdata <= 16'h0000;
		end
	end
	assign bus.rdata = rdata;

endmodule : edint_dev

// ===== hdl/edint_map.svh
`ifndef EDINT_MAP_SVH
`define EDINT_MAP_SVH
// Device register offsets.
`define EDINT_OFF_CSR     8'h02
`define EDINT_OFF_POL     8'h06
`define EDINT_OFF_MIC     8'h08
`define EDINT_OFF_CHEN    8'h0a
`define EDINT_OFF_DEF     8'h0c
`define EDINT_OFF_PEND    8'h10
// Master interrupt control fields.
`define EDINT_MIC_VEC_LSB 0
`define EDINT_MIC_VEC_MSB 7
`define EDINT_MIC_IE      8
`define EDINT_MIC_IT      9
`define EDINT_MIC_PAT     10
`define EDINT_MIC_STORED_IRQ_ENABLE    11
`define EDINT_MIC_FULL_IRQ_ENABLE    12
`define EDINT_MIC_HALF_IRQ_ENABLE    13
`define EDINT_MIC_ROLLOVER_IRQ_ENABLE    14
// Control and status fields.
`define EDINT_CSR_DS      0
`define EDINT_CSR_FF      1
`define EDINT_CSR_HF      2
`define EDINT_CSR_TSR     3
`define EDINT_CSR_RFF     4
// Reset values.
`define EDINT_RST_REG     16'h0000
`define EDINT_RST_VEC     8'h00
// Host register offsets and fields.
`define EDINT_HOFF_CTRL   8'h80
`define EDINT_HOFF_STAT   8'h82
`define EDINT_HSEL_BIT    7
`define EDINT_HCTRL_AUTO  0
`define EDINT_HSTAT_IRQ   0
`define EDINT_HSTAT_VVAL  1
`endif

// ===== hdl/edint_pkg.sv
package edint_pkg;
	typedef logic [15:0] edint_word_t;
	typedef logic [7:0]  edint_addr_t;
	typedef logic [7:0]  edint_vec_t;
	typedef enum logic [2:0] {
		EDINT_H_IDLE = 3'b001,
		EDINT_H_ACK  = 3'b010,
		EDINT_H_WAIT = 3'b100
	} edint_hstate_t;
endpackage : edint_pkg

// ===== hdl/edint_if.sv
`timescale 1ns/1ps
interface edint_if;
	import edint_pkg::*;
	edint_addr_t addr;
	edint_word_t wdata;
	logic        wr;
	logic        rd;
	edint_word_t rdata;
	logic        irq;
	logic        iack;
	logic        vec_oe;
	edint_vec_t  vec;
	modport dev (input addr, input wdata, input wr, input rd, output rdata,
		output irq, input iack, output vec_oe, output vec);
	modport host (output addr, output wdata, output wr, output rd, input rdata,
		input irq, output iack, input vec_oe, input vec);
endinterface : edint_if

// ===== hdl/edint_host.sv
`timescale 1ns/1ps
`include "edint_map.svh"
module edint_host (
	// Clock and reset.
	input  wire logic                   i_clock,
	input  wire logic                   i_rst_n,
	// Link to the device.
	edint_if.host                       bus,
	// Software port.
	input  wire edint_pkg::edint_addr_t i_addr,
	input  wire edint_pkg::edint_word_t i_wdata,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	output edint_pkg::edint_word_t      o_rdata
);
	import edint_pkg::*;

	edint_hstate_t state;
	logic          auto_ack;
	logic          vec_valid;
	edint_vec_t    vec_seen;
	logic          fwd_rd_q;
	edint_word_t   own_rdata;
	logic          own_sel;
	logic          wr_stat;

	// Addresses with the select bit clear pass straight to the device.
	assign own_sel   = i_addr[`EDINT_HSEL_BIT];
	assign bus.addr  = i_addr;
	assign bus.wdata = i_wdata;
	assign bus.wr    = i_wr && !own_sel;
	assign bus.rd    = i_rd && !own_sel;
	assign bus.iack  = (state == EDINT_H_ACK);
	assign wr_stat   = i_wr && (i_addr == `EDINT_HOFF_STAT);

	// Acknowledge sequencer: one cycle of acknowledge per request, then wait
	// for the line to fall so a software-release request is not re-acked.
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			state <= EDINT_H_IDLE;
		end else begin
			unique case (state)
				EDINT_H_IDLE: if (auto_ack && bus.irq) state <= EDINT_H_ACK;
				EDINT_H_ACK:  state <= EDINT_H_WAIT;
				EDINT_H_WAIT: if (!bus.irq) state <= EDINT_H_IDLE;
				default:      state <= EDINT_H_IDLE;
			endcase
		end
	end

	// Control register.
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			auto_ack <= 1'b0;
		end else if (i_wr && (i_addr == `EDINT_HOFF_CTRL)) begin
			auto_ack <= i_wdata[`EDINT_HCTRL_AUTO];
		end
	end

	// Captured vector; a capture in the clearing cycle wins.
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			vec_valid <= 1'b0;
			vec_seen  <= `EDINT_RST_VEC;
		end else if (bus.iack && bus.vec_oe) begin
			vec_valid <= 1'b1;
			vec_seen  <= bus.vec;
		end else if (wr_stat && i_wdata[`EDINT_HSTAT_VVAL]) begin
			vec_valid <= 1'b0;
		end
	end

	// Own read data and the select of the next cycle's answer.
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			own_rdata <= 16'h0000;
			fwd_rd_q  <= 1'b0;
		end else begin
			fwd_rd_q  <= i_rd && !own_sel;
			own_rdata <= 16'h0000;
			if (i_rd && (i_addr == `EDINT_HOFF_CTRL)) begin
				own_rdata <= {15'h0, auto_ack};
			end else if (i_rd && (i_addr == `EDINT_HOFF_STAT)) begin
				own_rdata <= {vec_seen, 6'h00, vec_valid, bus.irq};
			end
		end
	end
	assign o_rdata = fwd_rd_q ? bus.rdata : own_rdata;

endmodule : edint_host

// ===== tb/edint_checker.sv
`timescale 1ns/1ps
module edint_checker (
	// Clock and reset.
	input wire logic                   i_clock,
	input wire logic                   i_rst_n,
	// Link signals between host and device.
	input wire edint_pkg::edint_addr_t addr,
	input wire edint_pkg::edint_word_t wdata,
	input wire logic                   wr,
	input wire logic                   rd,
	input wire edint_pkg::edint_word_t rdata,
	input wire logic                   irq,
	input wire logic                   iack,
	input wire logic                   vec_oe,
	input wire edint_pkg::edint_vec_t  vec
);
	import edint_pkg::*;
	edint_word_t mic;
	// Shadow of the master control word, so each check knows the mode in force.
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			mic <= 16'h0000;
		end else if (wr && addr == 8'h08) begin
			mic <= wdata;
		end
	end
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);
	AST_LINE_GATE: assert property (irq |-> mic[8])
		else $error("request seen with line enable off");
	AST_HW_RELEASE: assert property (iack && mic[9] |-> !irq && vec_oe)
		else $error("hardware release did not drop request with vector");
	AST_SW_NO_VEC: assert property (iack && !mic[9] |-> !vec_oe)
		else $error("vector driven in software release mode");
	AST_VEC_ONLY_ACK: assert property (vec_oe |-> iack && mic[9])
		else $error("vector driven outside hardware acknowledge");
	AST_COMMON_VEC: assert property (vec_oe |-> vec == mic[7:0])
		else $error("vector differs from programmed field");
	AST_MIC_READ: assert property (rd && addr == 8'h08 |=> rdata[14:0] == mic[14:0])
		else $error("control word read back wrong");
	AST_IACK_PULSE: assert property (iack |=> !iack)
		else $error("acknowledge longer than one cycle");
	AST_ACK_AFTER_REQ: assert property ($rose(iack) |-> $past(irq))
		else $error("acknowledge without prior request");
	// Checked through reset itself, so the default disable is overridden here.
	AST_RESET_QUIET: assert property (disable iff (1'b0)
		!i_rst_n |=> !irq && !vec_oe && rdata == 16'h0000)
		else $error("outputs not quiet after reset");
	COV_HW_ACK: cover property (iack && mic[9]);
	COV_SW_ACK: cover property (iack && !mic[9]);
	COV_MIC_READ: cover property (rd && addr == 8'h08);
endmodule : edint_checker

// ===== tb/event_detector_interrupt_logic_tb.sv
`timescale 1ns/1ps
module event_detector_interrupt_logic_tb;
	import edint_pkg::*;
	typedef struct {edint_addr_t a; edint_word_t d; edint_word_t e;} edint_row_t;
	logic        i_clock, i_rst_n, i_wr, i_rd, o_fifo_clear;
	logic        i_fifo_empty, i_fifo_full, i_fifo_half, i_ts_wrap, i_sample_tick;
	edint_addr_t i_addr;
	edint_word_t i_wdata, o_rdata, i_inputs, v;
	int          err_total, num_checks, clr_n;
	// Register rows: the unmapped offset must read zero and swallow the write.
	edint_row_t  rows [5] = '{'{8'h06, 16'h0002, 16'h0002}, '{8'h0a, 16'h0007, 16'h0007},
		'{8'h0c, 16'h0003, 16'h0003}, '{8'h08, 16'h00a5, 16'h00a5}, '{8'h04, 16'h1234, 16'h0000}};
	// Channel inputs per tick and the pending word expected after each.
	edint_word_t cin [5] = '{16'h0000, 16'h0008, 16'h0001, 16'h0002, 16'h0004};
	edint_word_t cex [5] = '{16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0007};
	edint_if u_edint_if ();
	edint_dev u_edint_dev (.i_clock, .i_rst_n, .bus(u_edint_if.dev), .i_fifo_empty,
		.i_fifo_full, .i_fifo_half, .i_ts_wrap, .o_fifo_clear, .i_sample_tick, .i_inputs);
	edint_host u_edint_host (.i_clock, .i_rst_n, .bus(u_edint_if.host), .i_addr, .i_wdata,
		.i_wr, .i_rd, .o_rdata);
	edint_checker u_edint_checker (.i_clock, .i_rst_n, .addr(u_edint_if.addr),
		.wdata(u_edint_if.wdata), .wr(u_edint_if.wr), .rd(u_edint_if.rd),
		.rdata(u_edint_if.rdata), .irq(u_edint_if.irq), .iack(u_edint_if.iack),
		.vec_oe(u_edint_if.vec_oe), .vec(u_edint_if.vec));
	initial begin
		i_clock = 1'b0;
		forever #20 i_clock = ~i_clock;
	end
	// Counts clear pulses; a pulse is one cycle, so it is caught at the edge.
	always @(posedge i_clock) begin
		if (o_fifo_clear === 1'b1) clr_n++;
	end
	task automatic chk(string n, edint_word_t s, edint_word_t e);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// Extra edges after the strobe let the forwarded write land in the device.
	task automatic wr_reg(edint_addr_t a, edint_word_t d);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
		repeat (2) @(posedge i_clock);
	endtask : wr_reg
	// A release write drops a standing status request for exactly one cycle.
	task automatic wr_drop(edint_addr_t a, edint_word_t d);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
		#1 chk("released irq", {15'h0, u_edint_if.irq}, 16'h0000);
	endtask : wr_drop
	task automatic rd_reg(edint_addr_t a, output edint_word_t d);
		@(posedge i_clock);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask : rd_reg
	task automatic ci(logic e);
		repeat (3) @(posedge i_clock);
		#1 chk("irq", {15'h0, u_edint_if.irq}, {15'h0, e});
	endtask : ci
	task automatic tick(edint_word_t x);
		@(posedge i_clock);
		i_inputs <= x;
		i_sample_tick <= 1'b1;
		@(posedge i_clock);
		i_sample_tick <= 1'b0;
	endtask : tick
	task automatic wrap();
		@(posedge i_clock);
		i_ts_wrap <= 1'b1;
		@(posedge i_clock);
		i_ts_wrap <= 1'b0;
	endtask : wrap
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim
	// A hang costs a mismatch; the tests need well under a thousand cycles.
	initial begin
		repeat (4000) @(posedge i_clock);
		err_total++;
		end_sim();
	end
	initial begin
		{i_rst_n, i_wr, i_rd, i_fifo_full, i_fifo_half, i_ts_wrap, i_sample_tick} = '0;
		{i_addr, i_wdata, i_inputs, err_total, num_checks, clr_n} = '0;
		i_fifo_empty = 1'b1;
		repeat (6) @(posedge i_clock);
		i_rst_n <= 1'b1;
		rd_reg(8'h08, v); chk("mic reset", v, 16'h0000);
		rd_reg(8'h02, v); chk("csr reset", v, 16'h0000);
		ci(1'b0);
		$display("reset test done");
		foreach (rows[i]) begin
			wr_reg(rows[i].a, rows[i].d);
			rd_reg(rows[i].a, v);
			chk("reg row", v, rows[i].e);
		end
		$display("register test done");
		wr_reg(8'h08, 16'h0800);
		@(posedge i_clock) i_fifo_empty <= 1'b0;
		ci(1'b0);
		rd_reg(8'h02, v); chk("stored flag", v & 16'h0001, 16'h0001);
		wr_reg(8'h08, 16'h0900); ci(1'b1);
		wr_drop(8'h02, 16'h0001); ci(1'b1);
		@(posedge i_clock) i_fifo_empty <= 1'b1;
		ci(1'b0);
		$display("stored test done");
		wr_reg(8'h08, 16'h1100);
		@(posedge i_clock) i_fifo_full <= 1'b1;
		@(posedge i_clock) i_fifo_full <= 1'b0;
		ci(1'b1);
		rd_reg(8'h02, v); chk("full sticky", v & 16'h0002, 16'h0002);
		wr_drop(8'h02, 16'h0002); ci(1'b1);
		wr_reg(8'h02, 16'h0010); ci(1'b0);
		chk("clear pulses", 16'(clr_n), 16'h0001);
		$display("full test done");
		wr_reg(8'h08, 16'h2100);
		@(posedge i_clock) i_fifo_half <= 1'b1;
		ci(1'b1);
		rd_reg(8'h02, v); chk("half flag", v & 16'h0004, 16'h0004);
		wr_drop(8'h02, 16'h0004); ci(1'b1);
		@(posedge i_clock) i_fifo_half <= 1'b0;
		ci(1'b0);
		wr_reg(8'h08, 16'h4100);
		wrap(); ci(1'b1);
		rd_reg(8'h02, v); chk("rollover flag", v & 16'h0008, 16'h0008);
		wr_reg(8'h02, 16'h0008); ci(1'b0);
		$display("status test done");
		wr_reg(8'h08, 16'h0100);
		foreach (cin[i]) begin
			tick(cin[i]);
			rd_reg(8'h10, v);
			chk("pending", v, cex[i]);
		end
		wr_reg(8'h10, 16'h0003);
		rd_reg(8'h10, v); chk("pending cleared", v, 16'h0004);
		ci(1'b1);
		wr_reg(8'h10, 16'h0004); ci(1'b0);
		tick(16'h0000);
		rd_reg(8'h10, v); chk("any change", v, 16'h0004);
		wr_reg(8'h10, 16'h0004);
		$display("channel test done");
		wr_reg(8'h0a, 16'h0003);
		wr_reg(8'h0c, 16'h0001);
		wr_reg(8'h08, 16'h0500);
		tick(16'h0001);
		rd_reg(8'h10, v); chk("no match", v, 16'h0000);
		tick(16'h00f3);
		rd_reg(8'h10, v); chk("match", v, 16'h0001);
		tick(16'h0000); ci(1'b1);
		wr_reg(8'h10, 16'h0001); ci(1'b0);
		$display("pattern test done");
		wr_reg(8'h80, 16'h0001);
		rd_reg(8'h80, v); chk("auto ack", v, 16'h0001);
		wr_reg(8'h08, 16'h43a5);
		wrap(); ci(1'b0);
		rd_reg(8'h82, v); chk("captured vector", v, 16'ha502);
		wr_reg(8'h82, 16'h0002);
		wr_reg(8'h08, 16'h41a5); ci(1'b1);
		rd_reg(8'h82, v); chk("no vector", v & 16'h0003, 16'h0001);
		wr_reg(8'h02, 16'h0008); ci(1'b0);
		$display("release test done");
		// Second reset with full and rollover flags, pending bit zero and auto-acknowledge set.
		wrap();
		tick(16'h0001);
		@(posedge i_clock) i_fifo_full <= 1'b1;
		@(posedge i_clock) i_fifo_full <= 1'b0;
		ci(1'b1);
		@(posedge i_clock) i_rst_n <= 1'b0;
		repeat (6) @(posedge i_clock);
		i_rst_n <= 1'b1;
		rd_reg(8'h08, v); chk("mic rerun", v, 16'h0000);
		rd_reg(8'h10, v); chk("pend rerun", v, 16'h0000);
		rd_reg(8'h02, v); chk("csr rerun", v, 16'h0000);
		rd_reg(8'h80, v); chk("ctrl rerun", v, 16'h0000);
		ci(1'b0);
		$display("reset rerun done");
		end_sim();
	end
endmodule : event_detector_interrupt_logic_tb
